// *** hwi_ctrl.sv ***
// Hold, wake-up and interrupt control
`timescale 1ns/1ns
module hwi_ctrl (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire hwi_pkg::hwi_cmd_s cmd_in,
  input wire hwi_pkg::hwi_src_s src_in,
  input wire logic [3:0] change_input_port_in,
  output logic hold_out,
  output logic irq_req_out,
  output logic [12:0] irq_vector_out,
  output logic [3:0] wake_cause_low_nibble_out,
  output logic [3:0] wake_cause_high_nibble_out,
  output logic [3:0] stop_wake_enable_out
);
  //==============================================================
  // Registers
  logic [7:0] wake_enable_mask;
  logic [7:0] irq_enable_mask;
  logic [3:0] pin_change_enable;
  logic [7:0] event_pending;
  logic [7:0] wake_cause;
  logic [3:0] port_meta;
  logic [3:0] port_sync;
  logic [3:0] port_prev;
  logic irq_allowed;
  logic [7:0] irq_src;
  hwi_pkg::hwi_state_e state;
  hwi_pkg::hwi_state_e next_state;
  logic [7:0] event_set;
  logic [7:0] release_hit;
  logic [7:0] cause_hit;
  logic [7:0] irq_pend;
  logic [7:0] next_irq_src;
  logic [12:0] next_vector;
  logic [3:0] pin_change;

  //==============================================================
  // Port pin synchroniser and change detect
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      port_meta <= 4'h0;
      port_sync <= 4'h0;
      port_prev <= 4'h0;
    end else begin
      port_meta <= change_input_port_in;
      port_sync <= port_meta;
      port_prev <= port_sync;
    end
  end

  assign pin_change = (port_sync ^ port_prev) & pin_change_enable;

  always_comb begin
    event_set = 8'h00;
    event_set[hwi_pkg::HWI_BIT_DIV0] = src_in.div0_overflow;
    event_set[hwi_pkg::HWI_BIT_TMR0] = src_in.tmr0_underflow;
    event_set[hwi_pkg::HWI_BIT_PORT] = |pin_change;
    event_set[hwi_pkg::HWI_BIT_DIV1] = src_in.div1_overflow;
    event_set[hwi_pkg::HWI_BIT_TMR1] = src_in.tmr1_underflow;
  end

  //==============================================================
  // Write-only masks
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wake_enable_mask <= hwi_pkg::HWI_RST_WAKE_EN;
      irq_enable_mask <= hwi_pkg::HWI_RST_IRQ_EN;
      pin_change_enable <= hwi_pkg::HWI_RST_PIN_EN;
      stop_wake_enable_out <= hwi_pkg::HWI_RST_STOP_EN;
    end else begin
      if (cmd_in.wr_wake_enable_mask) begin
        wake_enable_mask <= cmd_in.data & hwi_pkg::HWI_SRC_MASK;
      end
      if (cmd_in.wr_irq_enable_mask) begin
        irq_enable_mask <= cmd_in.data & hwi_pkg::HWI_SRC_MASK;
      end
      if (cmd_in.wr_pin_change_enable) begin
        pin_change_enable <= cmd_in.data[3:0];
      end
      if (cmd_in.wr_stop_wake_enable) begin
        stop_wake_enable_out <= cmd_in.data[3:0];
      end
    end
  end

  //==============================================================
  // Event flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      event_pending <= hwi_pkg::HWI_RST_EVENT;
    end else begin
      event_pending <= (event_pending
                        & ~(cmd_in.event_clear_instr ? cmd_in.data : 8'h00)
                        & ~(cmd_in.irq_accept ? irq_src : 8'h00))
                       | event_set;
    end
  end

  //==============================================================
  // Release and wake cause
  assign release_hit = event_pending & wake_enable_mask;

  always_comb begin
    cause_hit = 8'h00;
    cause_hit[hwi_pkg::HWI_CAUSE_DIV0] = release_hit[hwi_pkg::HWI_BIT_DIV0];
    cause_hit[hwi_pkg::HWI_CAUSE_TMR0] = release_hit[hwi_pkg::HWI_BIT_TMR0];
    cause_hit[hwi_pkg::HWI_CAUSE_PORT] = release_hit[hwi_pkg::HWI_BIT_PORT];
    cause_hit[hwi_pkg::HWI_CAUSE_DIV1] = release_hit[hwi_pkg::HWI_BIT_DIV1];
    cause_hit[hwi_pkg::HWI_CAUSE_TMR1] = release_hit[hwi_pkg::HWI_BIT_TMR1];
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wake_cause <= hwi_pkg::HWI_RST_CAUSE;
    end else if (state == hwi_pkg::HWI_HOLD || cmd_in.hold_instr) begin
      wake_cause <= (wake_cause & cause_hit) | cause_hit;
    end else begin
      wake_cause <= wake_cause & cause_hit;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wake_cause_low_nibble_out <= 4'h0;
      wake_cause_high_nibble_out <= 4'h0;
    end else begin
      wake_cause_low_nibble_out <= wake_cause[3:0];
      wake_cause_high_nibble_out <= wake_cause[7:4];
    end
  end

  //==============================================================
  // Interrupt request, lowest bit first
  assign irq_pend = event_pending & irq_enable_mask;

  always_comb begin
    next_irq_src = 8'h00;
    next_vector = hwi_pkg::HWI_VEC_FIRST;
    if (irq_pend[hwi_pkg::HWI_BIT_DIV0]) begin
      next_irq_src[hwi_pkg::HWI_BIT_DIV0] = 1'b1;
      next_vector = hwi_pkg::HWI_VEC_DIV0;
    end else if (irq_pend[hwi_pkg::HWI_BIT_TMR0]) begin
      next_irq_src[hwi_pkg::HWI_BIT_TMR0] = 1'b1;
      next_vector = hwi_pkg::HWI_VEC_TMR0;
    end else if (irq_pend[hwi_pkg::HWI_BIT_PORT]) begin
      next_irq_src[hwi_pkg::HWI_BIT_PORT] = 1'b1;
      next_vector = hwi_pkg::HWI_VEC_PORT;
    end else if (irq_pend[hwi_pkg::HWI_BIT_DIV1]) begin
      next_irq_src[hwi_pkg::HWI_BIT_DIV1] = 1'b1;
      next_vector = hwi_pkg::HWI_VEC_DIV1;
    end else if (irq_pend[hwi_pkg::HWI_BIT_TMR1]) begin
      next_irq_src[hwi_pkg::HWI_BIT_TMR1] = 1'b1;
      next_vector = hwi_pkg::HWI_VEC_TMR1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_allowed <= 1'b0;
    end else if (cmd_in.global_irq_off_instr) begin
      irq_allowed <= 1'b0;
    end else if (cmd_in.global_irq_on_instr || cmd_in.wr_irq_enable_mask) begin
      irq_allowed <= 1'b1;
    end else if (cmd_in.irq_accept) begin
      irq_allowed <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_req_out <= 1'b0;
      irq_src <= 8'h00;
      irq_vector_out <= hwi_pkg::HWI_VEC_FIRST;
    end else begin
      irq_req_out <= irq_allowed && (|irq_pend) && !cmd_in.irq_accept;
      irq_src <= next_irq_src;
      irq_vector_out <= next_vector;
    end
  end

  //==============================================================
  // Hold state machine
  always_comb begin
    next_state = state;
    case (state)
      hwi_pkg::HWI_RUN: begin
        if (cmd_in.hold_instr && wake_cause == 8'h00 && cause_hit == 8'h00) begin
          next_state = hwi_pkg::HWI_HOLD;
        end
      end
      hwi_pkg::HWI_HOLD: begin
        if (|cause_hit) begin
          next_state = hwi_pkg::HWI_RUN;
        end else if (irq_req_out) begin
          next_state = hwi_pkg::HWI_SERVICE;
        end
      end
      hwi_pkg::HWI_SERVICE: begin
        if (cmd_in.return_instr) begin
          next_state = (|wake_cause) ? hwi_pkg::HWI_RUN : hwi_pkg::HWI_HOLD;
        end
      end
      default: begin
        next_state = hwi_pkg::HWI_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state <= hwi_pkg::HWI_RUN;
      hold_out <= 1'b0;
    end else begin
      state <= next_state;
      hold_out <= (next_state == hwi_pkg::HWI_HOLD);
    end
  end

  //==============================================================
  // Checks
  hold_enter_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == hwi_pkg::HWI_RUN && cmd_in.hold_instr && wake_cause == 8'h00
     && cause_hit == 8'h00) |=> hold_out)
    else $error("hold not entered");
  hold_void_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == hwi_pkg::HWI_RUN && |wake_cause) |=> !hold_out)
    else $error("hold entered with cause set");
  wake_release_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == hwi_pkg::HWI_HOLD && |release_hit) |=> (!hold_out && |wake_cause))
    else $error("release did not wake");
  accept_clear_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (cmd_in.irq_accept && !cmd_in.event_clear_instr && !(|event_set)) |=>
      event_pending == ($past(event_pending) & ~$past(irq_src)))
    else $error("accept cleared wrong bits");
  irq_block_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (cmd_in.irq_accept && !cmd_in.global_irq_on_instr && !cmd_in.wr_irq_enable_mask)
      ##1 (!cmd_in.global_irq_on_instr && !cmd_in.wr_irq_enable_mask) |=> !irq_req_out)
    else $error("interrupt not blocked");
  irq_gate_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    irq_req_out |-> $past(|(event_pending & irq_enable_mask)))
    else $error("request without enabled event");
  event_set_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    src_in.tmr1_underflow |=> event_pending[hwi_pkg::HWI_BIT_TMR1])
    else $error("event lost");
  cause_clear_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (cmd_in.wr_wake_enable_mask && cmd_in.data == 8'h00 && state != hwi_pkg::HWI_HOLD
     && !cmd_in.hold_instr) |=> ##1 wake_cause == 8'h00)
    else $error("cause not cleared");
  pin_gate_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (pin_change_enable == 4'h0 && $stable(pin_change_enable)
     && !event_pending[hwi_pkg::HWI_BIT_PORT]) |=> !event_pending[hwi_pkg::HWI_BIT_PORT])
    else $error("disabled pin set event");
  isr_return_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == hwi_pkg::HWI_SERVICE && cmd_in.return_instr && wake_cause == 8'h00)
      |=> hold_out)
    else $error("no return to hold");
  hold_wake_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    hold_out ##[1:50] (!hold_out && |wake_cause));
  hold_isr_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    state == hwi_pkg::HWI_SERVICE ##[1:50] hold_out);
  irq_taken_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    irq_req_out ##1 cmd_in.irq_accept);
endmodule // hwi_ctrl

// *** hwi_pkg.sv ***
// Constants and types for the hold, wake-up and interrupt control block
//==============================================================
package hwi_pkg;
  //==============================================================
  // Source bit positions in event and mask registers
  localparam int unsigned HWI_BIT_DIV0 = 0;
  localparam int unsigned HWI_BIT_TMR0 = 1;
  localparam int unsigned HWI_BIT_PORT = 2;
  localparam int unsigned HWI_BIT_DIV1 = 4;
  localparam int unsigned HWI_BIT_TMR1 = 7;
  // Wake cause bit positions
  localparam int unsigned HWI_CAUSE_DIV0 = 0;
  localparam int unsigned HWI_CAUSE_TMR0 = 1;
  localparam int unsigned HWI_CAUSE_PORT = 2;
  localparam int unsigned HWI_CAUSE_DIV1 = 4;
  localparam int unsigned HWI_CAUSE_TMR1 = 5;
  // Implemented bits
  localparam logic [7:0] HWI_SRC_MASK = 8'h97;
  localparam logic [7:0] HWI_CAUSE_MASK = 8'h37;
  //==============================================================
  // Reset values
  localparam logic [7:0] HWI_RST_WAKE_EN = 8'h00;
  localparam logic [7:0] HWI_RST_IRQ_EN = 8'h00;
  localparam logic [3:0] HWI_RST_PIN_EN = 4'h0;
  localparam logic [3:0] HWI_RST_STOP_EN = 4'h0;
  localparam logic [7:0] HWI_RST_EVENT = 8'h00;
  localparam logic [7:0] HWI_RST_CAUSE = 8'h00;
  //==============================================================
  // Vector addresses, bounded by first and last
  localparam logic [12:0] HWI_VEC_FIRST = 13'h0004;
  localparam logic [12:0] HWI_VEC_LAST = 13'h0020;
  localparam logic [12:0] HWI_VEC_DIV0 = 13'h0004;
  localparam logic [12:0] HWI_VEC_TMR0 = 13'h0008;
  localparam logic [12:0] HWI_VEC_PORT = 13'h000c;
  localparam logic [12:0] HWI_VEC_DIV1 = 13'h0010;
  localparam logic [12:0] HWI_VEC_TMR1 = 13'h0014;
  //==============================================================
  // Types
  typedef enum logic [1:0] {HWI_RUN, HWI_HOLD, HWI_SERVICE} hwi_state_e;
  typedef struct packed {
    logic hold_instr;
    logic global_irq_on_instr;
    logic global_irq_off_instr;
    logic return_instr;
    logic wr_wake_enable_mask;
    logic wr_irq_enable_mask;
    logic wr_pin_change_enable;
    logic wr_stop_wake_enable;
    logic event_clear_instr;
    logic irq_accept;
    logic [7:0] data;
  } hwi_cmd_s;
  typedef struct packed {
    logic div0_overflow;
    logic tmr0_underflow;
    logic div1_overflow;
    logic tmr1_underflow;
  } hwi_src_s;
endpackage

// *** hwi_src_model.sv ***
// Model of the timer, divider and input port event sources
`timescale 1ns/1ns
module hwi_src_model (
  input wire logic clk_sys_in,
  output hwi_pkg::hwi_src_s src_out,
  output logic [3:0] change_input_port_out
);
  //==============================================================
  // Sources
  initial begin
    src_out = '0;
    change_input_port_out = 4'h0;
  end
  // One-cycle overflow and underflow pulses, also while the core is halted
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_sys_in);
    src_out <= hwi_pkg::hwi_src_s'(m);
    @(posedge clk_sys_in);
    src_out <= '0;
  endtask
  // Level change on selected port pins
  task automatic toggle(input logic [3:0] m);
    @(posedge clk_sys_in);
    change_input_port_out <= change_input_port_out ^ m;
  endtask
endmodule // hwi_src_model

// *** tb_top.sv ***
// Self-checking testbench for the hold, wake-up and interrupt control block
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  //==============================================================
  // Strobe selects above the operand, and per-source table
  localparam logic [9:0] HOLD = 10'h200, ON = 10'h100, OFF = 10'h080, RET = 10'h040;
  localparam logic [9:0] WWK = 10'h020, WIQ = 10'h010, WPN = 10'h008, WST = 10'h004;
  localparam logic [9:0] CLR = 10'h002, ACC = 10'h001;
  localparam logic [7:0] WK [5] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h80};
  localparam logic [7:0] CS [5] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h20};
  localparam logic [3:0] SP [5] = '{4'h8, 4'h4, 4'h0, 4'h2, 4'h1};
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  hwi_pkg::hwi_cmd_s cmd = '0;
  hwi_pkg::hwi_src_s src;
  logic [3:0] pins;
  logic hold, irq_req;
  logic [12:0] vec;
  logic [3:0] cl, ch, stop;
  int n_fail = 0;
  int n_tests = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  hwi_src_model i_src (.clk_sys_in(clk_sys_in), .src_out(src), .change_input_port_out(pins));
  hwi_ctrl i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_in(cmd), .src_in(src),
    .change_input_port_in(pins), .hold_out(hold), .irq_req_out(irq_req),
    .irq_vector_out(vec), .wake_cause_low_nibble_out(cl),
    .wake_cause_high_nibble_out(ch), .stop_wake_enable_out(stop));
  //==============================================================
  // Tasks
  task automatic op(input logic [9:0] s, input logic [7:0] d);
    @(posedge clk_sys_in);
    cmd <= hwi_pkg::hwi_cmd_s'({s, d});
    @(posedge clk_sys_in);
    cmd <= '0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic wait_sig(input bit is_irq, input logic v, input string nm);
    int k;
    k = 0;
    @(negedge clk_sys_in);
    while (((is_irq ? irq_req : hold) !== v) && k < 20) begin
      @(negedge clk_sys_in);
      k++;
    end
    `CHK(nm, v, (is_irq ? irq_req : hold))
  endtask
  task automatic do_reset();
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    idle(4);
    `CHK("reset state", {2'b00, 13'h0004, 12'h000}, {hold, irq_req, vec, ch, cl, stop})
    @(posedge clk_sys_in);
    rst_in <= 1'b0;
  endtask
  task automatic close_out();
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    n_fail++;
    close_out();
  end
  //==============================================================
  // Tests
  initial begin
    do_reset();
    op(WPN, 8'h04);
    for (int i = 0; i < 5; i++) begin
      op(WWK, WK[i]);
      op(HOLD, 8'h00);
      wait_sig(1'b0, 1'b1, "hold entry");
      if (i == 2) begin
        i_src.toggle(4'hb);
        idle(10);
        `CHK("disabled pin", 1'b1, hold)
        i_src.toggle(4'h4);
      end else begin
        i_src.pulse(SP[i]);
      end
      wait_sig(1'b0, 1'b0, "hold release");
      idle(2);
      `CHK("wake cause", CS[i], {ch, cl})
      op(HOLD, 8'h00);
      idle(3);
      `CHK("hold void", 1'b0, hold)
      op((i % 2) ? CLR : WWK, (i % 2) ? WK[i] : 8'h00);
      idle(3);
      `CHK("cause cleared", 8'h00, {ch, cl})
    end
    op(CLR, 8'hff);
    op(WIQ, 8'h03);
    i_src.pulse(4'hc);
    wait_sig(1'b1, 1'b1, "irq div0");
    `CHK("vector div0", 13'h0004, vec)
    op(ACC, 8'h00);
    idle(3);
    `CHK("irq blocked", 1'b0, irq_req)
    op(ON, 8'h00);
    wait_sig(1'b1, 1'b1, "irq tmr0");
    `CHK("vector tmr0", 13'h0008, vec)
    op(ACC, 8'h00);
    op(ON, 8'h00);
    idle(3);
    `CHK("no stale irq", 1'b0, irq_req)
    op(WIQ, 8'h10);
    i_src.pulse(4'h2);
    wait_sig(1'b1, 1'b1, "irq div1");
    `CHK("vector div1", 13'h0010, vec)
    op(OFF, 8'h00);
    idle(3);
    `CHK("global off", 1'b0, irq_req)
    op(CLR, 8'hff);
    op(WIQ, 8'h68);
    i_src.pulse(4'hf);
    idle(6);
    `CHK("reserved irq bits", 1'b0, irq_req)
    op(WIQ, 8'h04);
    i_src.toggle(4'h4);
    wait_sig(1'b1, 1'b1, "irq port");
    `CHK("vector port", 13'h000c, vec)
    op(OFF, 8'h00);
    op(CLR, 8'hff);
    op(WST, 8'h0a);
    idle(2);
    `CHK("stop enable", 4'ha, stop)
    op(WWK, 8'h00);
    op(WIQ, 8'h80);
    op(HOLD, 8'h00);
    wait_sig(1'b0, 1'b1, "hold for irq");
    i_src.pulse(4'h1);
    wait_sig(1'b1, 1'b1, "irq in hold");
    idle(1);
    `CHK("service running", {1'b0, 13'h0014}, {hold, vec})
    op(ACC, 8'h00);
    op(RET, 8'h00);
    wait_sig(1'b0, 1'b1, "hold again");
    do_reset();
    op(WWK, 8'h68);
    op(HOLD, 8'h00);
    wait_sig(1'b0, 1'b1, "hold reserved");
    i_src.pulse(4'hf);
    idle(8);
    `CHK("reserved wake bits", 1'b1, hold)
    close_out();
  end
endmodule // tb_top
